// *** pkg/bitop_pkg.sv ***
// Purpose: Constants for the branch and bit-operation execute block
// Assumes: 16-bit instruction words, 21-bit byte program counter
// Notes: Opcode values sit in the upper bits of the instruction word
package bitop_pkg;
  localparam int PC_W = 21;
  localparam int FADDR_W = 12;
  // Upper byte of conditional branches
  localparam logic [7:0] OP_BR_ZERO_CLEAR = 8'h00_E1;
  localparam logic [7:0] OP_BR_OVF_SET = 8'h00_E4;
  // Upper five bits of the always-taken jump
  localparam logic [4:0] OP_JUMP_ALWAYS = 5'h0_1A;
  // Upper nibble of bit operations
  localparam logic [3:0] OP_BIT_SET = 4'h8;
  localparam logic [3:0] OP_BIT_INVERT = 4'h7;
  localparam logic [3:0] OP_SKIP_LOW = 4'hB;
  localparam logic [3:0] OP_SKIP_HIGH = 4'hA;
  // Field positions
  localparam int BIT_SEL_LSB = 9;
  localparam int ABIT_POS = 8;
  // Access bank split and literal-offset ceiling
  localparam logic [7:0] ACCESS_LOW_MAX = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // Fixed advance of the counter past the current word
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
  localparam int QPHASES = 4;
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } qphase_t;
endpackage : bitop_pkg

// *** hw/bitop_addr_gen.sv ***
// Purpose: File operand address generator for bit operations
// Assumes: Index register supplied by the core
// Notes: Purely combinational
module bitop_addr_gen #(
  parameter int FADDR_W = 12
) (
  input wire logic [7:0] f_i,
  input wire logic a_i,
  input wire logic ext_en_i,
  input wire logic [3:0] bank_sel_i,
  input wire logic [FADDR_W-1:0] index_i,
  output logic [FADDR_W-1:0] addr_o
);
  wire logic use_literal_off;
  wire logic [FADDR_W-1:0] access_addr;
  wire logic [FADDR_W-1:0] bank_addr;
  wire logic [FADDR_W-1:0] lit_addr;
  // Literal offset only below the split point
  assign use_literal_off = !a_i && ext_en_i && (f_i <= bitop_pkg::ACCESS_LOW_MAX);
  assign access_addr = (f_i <= bitop_pkg::ACCESS_LOW_MAX) ?
    {4'h0, f_i} : {bitop_pkg::ACCESS_HIGH_BANK, f_i};
  assign bank_addr = {bank_sel_i, f_i};
  assign lit_addr = index_i + {4'h0, f_i};
  assign addr_o = use_literal_off ? lit_addr : (a_i ? bank_addr : access_addr);
endmodule : bitop_addr_gen

// *** hw/branch_bit_op_execute.sv ***
// Purpose: Execute branches, bit set/invert and bit-test-skip in Q phases
// Assumes: Prefetched word arrives with instr_valid_i; file data read in Q2
// Notes: Flags are inputs from the status logic and are never written here
// How it works
// - Zero-clear branch jumps only when zero flag clear
// - Overflow branch jumps only when overflow set
// - Target is PC plus two plus twice offset
// - Not taken one cycle, taken adds idle cycle
// - Skip when tested bit matches low/high variant
// - Skip flushes prefetch, runs idle cycle instead
// - Invert selects bit, writes back, flags untouched
// - a=0 access bank, a=1 bank select register
// - Extended set, a=0, f<=5Fh uses literal offset
module branch_bit_op_execute #(
  parameter int PC_W = bitop_pkg::PC_W,
  parameter int FADDR_W = bitop_pkg::FADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic zero_flag_i,
  input wire logic ovf_flag_i,
  input wire logic ext_en_i,
  input wire logic [3:0] bank_sel_i,
  input wire logic [FADDR_W-1:0] index_i,
  input wire logic [7:0] file_rdata_i,
  output logic [PC_W-1:0] pc_o,
  output logic [1:0] qphase_o,
  output logic [FADDR_W-1:0] file_addr_o,
  output logic file_rd_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  output logic flush_o,
  output logic idle_o
);
  bitop_pkg::qphase_t q_q, q_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [15:0] ir_q, ir_d;
  logic idle_q, idle_d;
  logic flush_q, flush_d;
  logic [FADDR_W-1:0] faddr_q;
  logic rd_q, we_q;
  logic [7:0] wdata_q;
  logic [7:0] rdat_q;

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                 input logic [PC_W-1:0] off_sx);
    // Counter already holds branch address plus two, so only twice the offset is added
    rel_target = pc + {off_sx[PC_W-2:0], 1'b0};
  endfunction : rel_target

  wire logic is_bnz = ir_q[15:8] == bitop_pkg::OP_BR_ZERO_CLEAR;
  wire logic is_bov = ir_q[15:8] == bitop_pkg::OP_BR_OVF_SET;
  wire logic is_jmp = ir_q[15:11] == bitop_pkg::OP_JUMP_ALWAYS;
  wire logic is_set = ir_q[15:12] == bitop_pkg::OP_BIT_SET;
  wire logic is_inv = ir_q[15:12] == bitop_pkg::OP_BIT_INVERT;
  wire logic is_skl = ir_q[15:12] == bitop_pkg::OP_SKIP_LOW;
  wire logic is_skh = ir_q[15:12] == bitop_pkg::OP_SKIP_HIGH;
  wire logic is_fileop = is_set || is_inv || is_skl || is_skh;
  wire logic [2:0] bsel = ir_q[bitop_pkg::BIT_SEL_LSB +: 3];
  wire logic [7:0] bmask = 8'h01 << bsel;
  wire logic tested_bit = |(rdat_q & bmask);
  wire logic [PC_W-1:0] off8_sx = {{(PC_W-8){ir_q[7]}}, ir_q[7:0]};
  wire logic [PC_W-1:0] off11_sx = {{(PC_W-11){ir_q[10]}}, ir_q[10:0]};
  wire logic take_bnz = is_bnz && !zero_flag_i;
  wire logic take_bov = is_bov && ovf_flag_i;
  wire logic take_br = take_bnz || take_bov || is_jmp;
  wire logic do_skip = (is_skl && !tested_bit) || (is_skh && tested_bit);
  wire logic [PC_W-1:0] br_target = is_jmp ? rel_target(pc_q, off11_sx) :
                                             rel_target(pc_q, off8_sx);
  wire logic [7:0] mod_data = is_set ? (rdat_q | bmask) : (rdat_q ^ bmask);
  wire logic [FADDR_W-1:0] faddr_next;
  wire logic busy_cycle = !idle_q && instr_valid_i;
  wire logic end_cycle = q_q == bitop_pkg::Q4;

  bitop_addr_gen #(
    .FADDR_W(FADDR_W)
  ) u_addr (
    .f_i(ir_q[7:0]),
    .a_i(ir_q[bitop_pkg::ABIT_POS]),
    .ext_en_i(ext_en_i),
    .bank_sel_i(bank_sel_i),
    .index_i(index_i),
    .addr_o(faddr_next)
  );

  assign q_d = bitop_pkg::qphase_t'(q_q + 2'd1);
  // Instruction latched at cycle end; flushed word replaced by idle
  assign ir_d = end_cycle ? instr_i : ir_q;
  assign idle_d = end_cycle ? ((busy_cycle && (take_br || do_skip)) || !instr_valid_i) :
                  idle_q;
  assign flush_d = end_cycle && busy_cycle && (take_br || do_skip);
  // Counter steps at every cycle end (Q4); taken branch overrides with target
  assign pc_d = !end_cycle ? pc_q :
                (busy_cycle && take_br) ? br_target : pc_q + bitop_pkg::PC_STEP;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q_q <= bitop_pkg::Q1;
      pc_q <= bitop_pkg::PC_RESET;
      ir_q <= 16'h0000;
      idle_q <= 1'b1;
      flush_q <= 1'b0;
    end else begin
      q_q <= q_d;
      pc_q <= pc_d;
      ir_q <= ir_d;
      idle_q <= idle_d;
      flush_q <= flush_d;
    end
  end

  // Read in Q2, modify in Q3, write in Q4; status flags are never driven
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      faddr_q <= '0;
      rd_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      rdat_q <= 8'h00;
    end else begin
      faddr_q <= faddr_next;
      rd_q <= busy_cycle && is_fileop && (q_q == bitop_pkg::Q1);
      if (rd_q) begin
        rdat_q <= file_rdata_i;
      end
      we_q <= busy_cycle && (is_set || is_inv) && (q_q == bitop_pkg::Q3);
      wdata_q <= mod_data;
    end
  end

  assign pc_o = pc_q;
  assign qphase_o = q_q;
  assign file_addr_o = faddr_q;
  assign file_rd_o = rd_q;
  assign file_wdata_o = wdata_q;
  assign file_we_o = we_q;
  assign flush_o = flush_q;
  assign idle_o = idle_q;

  sequence s_taken_end;
    end_cycle && busy_cycle && take_br;
  endsequence

  sequence s_skip_end;
    end_cycle && busy_cycle && do_skip;
  endsequence

  sequence s_rmw_end;
    end_cycle && busy_cycle && (is_set || is_inv);
  endsequence

  sequence s_read_start;
    busy_cycle && is_fileop && (q_q == bitop_pkg::Q1);
  endsequence

  // Skip advances the counter only; it must never look like a jump
  a_skip_pc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_skip_end |=> pc_q == $past(pc_q) + 21'h00_0002)
    else $error("skip moved counter wrongly");
  // Read-modify-write ops finish in one cycle with no flush
  a_rmw_single: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_rmw_end |=> !idle_q && !flush_q)
    else $error("bit write op took an extra cycle");
  a_read_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_read_start |=> file_rd_o ##1 !file_rd_o)
    else $error("file read strobe wrong");
  a_write_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    file_we_o |=> !file_we_o)
    else $error("file write strobe too long");
  // Idle cycle must not touch the register file
  a_idle_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    idle_q |-> !file_we_o && !file_rd_o)
    else $error("idle cycle accessed file");
  a_set_noflush: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (end_cycle && busy_cycle && is_set) |=> !flush_q)
    else $error("bit set flushed prefetch");

  a_branch_target: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_taken_end |=> pc_q == $past(br_target))
    else $error("branch target wrong");
  a_bnz_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (end_cycle && busy_cycle && is_bnz && zero_flag_i) |=> pc_q == $past(pc_q) + 21'h00_0002)
    else $error("zero-clear branch taken with zero set");
  a_bov_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (end_cycle && busy_cycle && is_bov && !ovf_flag_i) |=> !idle_q && !flush_q)
    else $error("overflow branch taken without overflow");
  a_taken_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_taken_end |=> idle_q [*4] ##1 !idle_q || !instr_valid_i)
    else $error("taken branch idle cycle wrong");
  a_jump_always: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (end_cycle && busy_cycle && is_jmp) |=> flush_q && idle_q)
    else $error("always jump not taken");
  a_skip_flush: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (end_cycle && busy_cycle && do_skip) |=> flush_q ##1 !flush_q)
    else $error("skip did not flush");
  a_skip_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    flush_q |-> idle_q && $stable(pc_q) == 1'b0)
    else $error("flushed word not idled");
  a_invert_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (file_we_o && $past(is_inv)) |-> file_wdata_o == ($past(rdat_q) ^ $past(bmask)))
    else $error("invert result wrong");
  a_set_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (file_we_o && $past(is_set)) |-> (file_wdata_o & $past(bmask)) != 8'h00)
    else $error("bit set result wrong");
  a_bank_pick: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (ir_q[8] && is_fileop) |=> file_addr_o == {$past(bank_sel_i), $past(ir_q[7:0])})
    else $error("bank select address wrong");
  a_lit_offset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!ir_q[8] && ext_en_i && ir_q[7:0] <= 8'h5F) |=>
      file_addr_o == $past(index_i) + {4'h0, $past(ir_q[7:0])})
    else $error("literal offset address wrong");
endmodule : branch_bit_op_execute

// *** bench/branch_bit_op_execute_tb_top.sv ***
// Purpose: Self-checking bench for the branch and bit-operation execute block
// Assumes: One word per 4-clock cycle, inputs driven by NBA on rising edges
// Notes: Target checked against pc_o seen during the executing cycle
module branch_bit_op_execute_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, rst_i, instr_valid_i, zero_flag_i, ovf_flag_i, ext_en_i;
  logic [15:0] instr_i;
  logic [3:0] bank_sel_i;
  logic [11:0] index_i, addr;
  logic [7:0] file_rdata_i, wdata;
  logic [20:0] pc_o, pc0, pc1;
  logic [1:0] qphase_o;
  logic [11:0] file_addr_o;
  logic file_rd_o, file_we_o, flush_o, idle_o, rd_seen, we_seen, fl, idl;
  logic [7:0] file_wdata_o;
  int bad_count, comparisons;
  branch_bit_op_execute i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .zero_flag_i(zero_flag_i), .ovf_flag_i(ovf_flag_i),
    .ext_en_i(ext_en_i), .bank_sel_i(bank_sel_i), .index_i(index_i),
    .file_rdata_i(file_rdata_i), .pc_o(pc_o), .qphase_o(qphase_o), .file_addr_o(file_addr_o),
    .file_rd_o(file_rd_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
    .flush_o(flush_o), .idle_o(idle_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Word goes in during Q4, executes in the following cycle
  task automatic run(input logic [15:0] w, input logic [7:0] rd);
    do @(posedge sys_clk_i); while (qphase_o !== 2'd2);
    instr_i <= w;
    file_rdata_i <= rd;
    @(posedge sys_clk_i);
    instr_i <= 16'h0000;
    @(posedge sys_clk_i);
    pc0 = pc_o;
    rd_seen = 1'b0;
    we_seen = 1'b0;
    repeat (3) begin
      @(posedge sys_clk_i);
      rd_seen = rd_seen | file_rd_o;
      if (file_we_o === 1'b1) begin
        we_seen = 1'b1;
        wdata = file_wdata_o;
        addr = file_addr_o;
      end
    end
    @(posedge sys_clk_i);
    pc1 = pc_o;
    fl = flush_o;
    idl = idle_o;
  endtask : run
  task automatic branch_zero_clear;
    zero_flag_i <= 1'b0;
    run({bitop_pkg::OP_BR_ZERO_CLEAR, 8'hFD}, 8'h00);
    check(pc1, pc0 - 21'h00_0006);
    check({fl, idl}, 2'h3);
    zero_flag_i <= 1'b1;
    run({bitop_pkg::OP_BR_ZERO_CLEAR, 8'hFD}, 8'h00);
    check(pc1, pc0 + 21'h00_0002);
    check({fl, idl}, 2'h0);
  endtask : branch_zero_clear
  task automatic branch_overflow;
    ovf_flag_i <= 1'b1;
    run({bitop_pkg::OP_BR_OVF_SET, 8'h7F}, 8'h00);
    check(pc1, pc0 + 21'h00_00FE);
    check({fl, idl}, 2'h3);
    ovf_flag_i <= 1'b0;
    zero_flag_i <= 1'b0;
    run({bitop_pkg::OP_BR_OVF_SET, 8'h7F}, 8'h00);
    check(pc1, pc0 + 21'h00_0002);
    check({fl, idl}, 2'h0);
  endtask : branch_overflow
  task automatic jump_always;
    run({bitop_pkg::OP_JUMP_ALWAYS, 11'h400}, 8'h00);
    check(pc1, pc0 + 21'h1F_F800);
    check({fl, idl}, 2'h3);
    run({bitop_pkg::OP_JUMP_ALWAYS, 11'h3FF}, 8'h00);
    check(pc1, pc0 + 21'h00_07FE);
  endtask : jump_always
  task automatic bit_set;
    bank_sel_i <= 4'h2;
    run({bitop_pkg::OP_BIT_SET, 3'd5, 1'b1, 8'h34}, 8'h81);
    check({rd_seen, we_seen, wdata}, 10'h3A1);
    check(addr, 12'h234);
    check(pc1, pc0 + 21'h00_0002);
    check({20'h0_0000, idl}, 21'h00_0000);
  endtask : bit_set
  task automatic inv_case(input logic e, input logic [15:0] w, input logic [7:0] rd,
                          input logic [7:0] wd, input logic [11:0] ad);
    ext_en_i <= e;
    run(w, rd);
    check({we_seen, wdata}, {1'b1, wd});
    check(addr, ad);
  endtask : inv_case
  // Both sides of the 5Fh literal-offset boundary
  task automatic bit_invert;
    inv_case(1'b0, {bitop_pkg::OP_BIT_INVERT, 3'd7, 1'b0, 8'h80}, 8'hA5, 8'h25, 12'hF80);
    inv_case(1'b0, {bitop_pkg::OP_BIT_INVERT, 3'd6, 1'b0, 8'h10}, 8'h00, 8'h40, 12'h010);
    inv_case(1'b1, {bitop_pkg::OP_BIT_INVERT, 3'd0, 1'b0, 8'h5F}, 8'h01, 8'h00, 12'h15F);
    inv_case(1'b1, {bitop_pkg::OP_BIT_INVERT, 3'd3, 1'b0, 8'h60}, 8'h00, 8'h08, 12'hF60);
    inv_case(1'b1, {bitop_pkg::OP_BIT_INVERT, 3'd1, 1'b1, 8'h60}, 8'hFF, 8'hFD, 12'h260);
  endtask : bit_invert
  task automatic bit_skip;
    logic hi, bv;
    for (int i = 0; i < 4; i++) begin
      hi = i[1];
      bv = i[0];
      run({hi ? bitop_pkg::OP_SKIP_HIGH : bitop_pkg::OP_SKIP_LOW, 3'd2, 1'b0, 8'h20},
          bv ? 8'h04 : 8'hFB);
      check({fl, idl}, {2{hi == bv}});
      check({rd_seen, we_seen}, 2'h2);
      check(pc1, pc0 + 21'h00_0002);
    end
  endtask : bit_skip
  task automatic results;
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // Whole run is about 130 clocks (16 words, 8 clocks each); generous margin
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    bad_count++;
    results();
  end
  initial begin
    rst_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b1;
    zero_flag_i = 1'b0;
    ovf_flag_i = 1'b0;
    ext_en_i = 1'b0;
    bank_sel_i = 4'h0;
    index_i = 12'h100;
    file_rdata_i = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    branch_zero_clear();
    branch_overflow();
    jump_always();
    bit_set();
    bit_invert();
    bit_skip();
    results();
  end
endmodule : branch_bit_op_execute_tb_top
